// file: verilog/wtc_top.sv
// Purpose: Wake timer control: register, slow oscillator state, two events
// Assumes: Register port is a synchronous single-cycle strobe interface
// Notes:   Events are one-cycle pulses on the crystal clock
// Behaviour
// (RULE_01) Power-down bit resets high; clearing it calibrates
// (RULE_02) Slow clock is crystal divided by 750
// (RULE_03) Second-event field bits 6:4 resets to 7
// (RULE_04) Field decodes to 4..48 slow periods
// (RULE_05) Calibration enable bit 3 resets high
// (RULE_06) Resolution bits 1:0 scale step, reset zero
// (RULE_07) Host keeps resolution low for wake polling
// (RULE_08) All resolution settings accepted without restriction
// (RULE_09) First event after 750*count*2^(5*res) cycles
// (RULE_10) First event starts delay and restarts period
// (RULE_11) Bit 2 reads zero, writes ignored
`timescale 1ns/1ns
`include "wtc_defs.svh"
module wtc_top
    import wtc_pkg::*;
#(
    parameter int DIV       = `WTC_XOSC_DIV,
    parameter int CAL_TICKS = `WTC_CAL_TICKS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Register port
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // Wake period count from the event-count registers
    input  wire logic [15:0] wake_period_count_i,
    // Timer status and events
    output logic             osc_on_o,
    output logic             cal_busy_o,
    output logic             cal_enable_o,
    output logic             wake_period_count_o,
    output logic             second_event_delay_o
);
    // Control register fields
    logic        slow_osc_powerdown_r;
    logic [2:0]  second_event_delay_r;
    logic        slow_osc_cal_enable_r;
    logic [1:0]  wake_period_resolution_r;

    wtc_osc_t    osc_r;
    wtc_osc_t    osc_nxt;
    logic [7:0]  cal_cnt_r;
    logic [14:0] pre_r;
    logic [15:0] ev0_cnt_r;
    logic [5:0]  ev1_cnt_r;
    logic        ev1_run_r;
    logic        ctrl_wr;
    logic        unit;
    logic        ev0_hit;
    logic        ev1_hit;

    wtc_tick_if tk ();

    // Second-event delay in slow periods
    function automatic logic [5:0] ev1_delay(input logic [2:0] sel);
        case (sel)
            3'h0:    ev1_delay = 6'h04; // [RULE_04]
            3'h1:    ev1_delay = 6'h06;
            3'h2:    ev1_delay = 6'h08;
            3'h3:    ev1_delay = 6'h0C;
            3'h4:    ev1_delay = 6'h10;
            3'h5:    ev1_delay = 6'h18;
            3'h6:    ev1_delay = 6'h20;
            default: ev1_delay = 6'h30;
        endcase
    endfunction

    // Last prescaler value for one wake-period step
    function automatic logic [14:0] pre_last(input logic [1:0] res);
        case (res)
            2'h0:    pre_last = 15'h0000; // [RULE_06]
            2'h1:    pre_last = 15'h001F;
            2'h2:    pre_last = 15'h03FF;
            default: pre_last = 15'h7FFF;
        endcase
    endfunction

    wtc_divider #(
        .DIV      (DIV)
    ) u_div (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .tk       (tk)
    );

    assign tk.osc_run = (osc_r != WTC_OSC_OFF);
    assign ctrl_wr    = reg_wr_i && (reg_addr_i == `WTC_ADDR_CTRL);
    // Every resolution setting is honoured as written
    // A prescaler left above a newly lowered limit ends its step at the next slow tick
    assign unit       = tk.tick && (pre_r >= pre_last(wake_period_resolution_r)); // [RULE_08]
    // Count of zero behaves as one step
    assign ev0_hit    = unit && ((ev0_cnt_r + 16'h0001) >= wake_period_count_i);
    assign ev1_hit    = tk.tick && ev1_run_r
                        && ((ev1_cnt_r + 6'h01) == ev1_delay(second_event_delay_r));

    // Control register fields
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slow_osc_powerdown_r     <= `WTC_RST_PD;  // [RULE_01]
            second_event_delay_r     <= `WTC_RST_EV1; // [RULE_03]
            slow_osc_cal_enable_r    <= `WTC_RST_CAL; // [RULE_05]
            wake_period_resolution_r <= `WTC_RST_RES; // [RULE_06]
        end else if (ctrl_wr) begin
            slow_osc_powerdown_r     <= reg_wdata_i[`WTC_BIT_PD];
            second_event_delay_r     <= reg_wdata_i[`WTC_EV1_HI:`WTC_EV1_LO]; // [RULE_03]
            slow_osc_cal_enable_r    <= reg_wdata_i[`WTC_BIT_CAL]; // [RULE_05]
            wake_period_resolution_r <= reg_wdata_i[`WTC_RES_HI:`WTC_RES_LO];
        end
    end

    // Read data, unused bit fixed at zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_addr_i == `WTC_ADDR_CTRL) begin
            reg_rdata_o <= {slow_osc_powerdown_r, second_event_delay_r,
                            slow_osc_cal_enable_r, 1'b0, wake_period_resolution_r}; // [RULE_11]
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Oscillator state: off, calibrating, running
    always_comb begin
        osc_nxt = osc_r;
        case (osc_r)
            WTC_OSC_OFF: begin
                if (ctrl_wr && !reg_wdata_i[`WTC_BIT_PD]) begin
                    osc_nxt = WTC_OSC_CAL; // [RULE_01]
                end
            end
            WTC_OSC_CAL: begin
                if (tk.tick && (cal_cnt_r == 8'(CAL_TICKS - 1))) begin
                    osc_nxt = WTC_OSC_RUN;
                end
            end
            WTC_OSC_RUN: begin
                if (ev0_hit && slow_osc_cal_enable_r) begin
                    osc_nxt = WTC_OSC_CAL; // [RULE_05]
                end
            end
            default: osc_nxt = WTC_OSC_OFF;
        endcase
        if (ctrl_wr && reg_wdata_i[`WTC_BIT_PD]) begin
            osc_nxt = WTC_OSC_OFF;
        end
    end

    // Oscillator state register and its outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_r        <= WTC_OSC_OFF;
            osc_on_o     <= 1'b0;
            cal_busy_o   <= 1'b0;
            cal_enable_o <= `WTC_RST_CAL;
        end else begin
            osc_r        <= osc_nxt;
            osc_on_o     <= (osc_nxt != WTC_OSC_OFF);
            cal_busy_o   <= (osc_nxt == WTC_OSC_CAL);
            cal_enable_o <= ctrl_wr ? reg_wdata_i[`WTC_BIT_CAL] : slow_osc_cal_enable_r;
        end
    end

    // Calibration length in slow periods
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cal_cnt_r <= 8'h00;
        end else if (osc_r != WTC_OSC_CAL) begin
            cal_cnt_r <= 8'h00;
        end else if (tk.tick) begin
            cal_cnt_r <= cal_cnt_r + 8'h01;
        end
    end

    // Resolution prescaler and wake-period counter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_r     <= 15'h0000;
            ev0_cnt_r <= 16'h0000;
            wake_period_count_o  <= 1'b0;
        end else if (osc_r == WTC_OSC_OFF) begin
            pre_r     <= 15'h0000;
            ev0_cnt_r <= 16'h0000;
            wake_period_count_o  <= 1'b0;
        end else begin
            wake_period_count_o <= ev0_hit; // [RULE_09]
            if (unit) begin
                pre_r     <= 15'h0000;
                ev0_cnt_r <= ev0_hit ? 16'h0000 : ev0_cnt_r + 16'h0001; // [RULE_10]
            end else if (tk.tick) begin
                pre_r     <= pre_r + 15'h0001;
            end
        end
    end

    // Second-event delay counter, started by each first event
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ev1_cnt_r <= 6'h00;
            ev1_run_r <= 1'b0;
            second_event_delay_o  <= 1'b0;
        end else if (osc_r == WTC_OSC_OFF) begin
            ev1_cnt_r <= 6'h00;
            ev1_run_r <= 1'b0;
            second_event_delay_o  <= 1'b0;
        end else begin
            second_event_delay_o <= ev1_hit && !ev0_hit;
            if (ev0_hit) begin
                ev1_cnt_r <= 6'h00; // [RULE_10]
                ev1_run_r <= 1'b1;
            end else if (ev1_hit) begin
                ev1_cnt_r <= ev1_cnt_r + 6'h01;
                ev1_run_r <= 1'b0;
            end else if (tk.tick && ev1_run_r) begin
                ev1_cnt_r <= ev1_cnt_r + 6'h01;
            end
        end
    end

    a_pd_wakes_cal: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_01]
        (osc_r == WTC_OSC_OFF) && ctrl_wr && !reg_wdata_i[`WTC_BIT_PD]
        |=> cal_busy_o && osc_on_o && !slow_osc_powerdown_r)
        else $error("clearing power-down did not start calibration");

    a_ev1_field_load: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_03]
        ctrl_wr |=> second_event_delay_r == $past(reg_wdata_i[`WTC_EV1_HI:`WTC_EV1_LO]))
        else $error("second-event field not loaded");

    a_ev1_delay_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_04]
        second_event_delay_o |-> ev1_cnt_r == ev1_delay($past(second_event_delay_r)))
        else $error("second event after wrong number of slow periods");

    a_cal_enable_out: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_05]
        ctrl_wr |=> cal_enable_o == $past(reg_wdata_i[`WTC_BIT_CAL]))
        else $error("calibration enable output does not follow the write");

    a_res_step_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_06]
        (osc_r != WTC_OSC_OFF) && tk.tick && !unit |=> pre_r == $past(pre_r) + 15'h0001)
        else $error("resolution prescaler did not advance on a slow tick");

    a_ev0_count_hit: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_09]
        wake_period_count_o |-> ev0_cnt_r == 16'h0000
                     && ($past(ev0_cnt_r) + 16'h0001) >= $past(wake_period_count_i))
        else $error("first event before the period count was reached");

    a_ev0_restart: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_10]
        wake_period_count_o |-> ev1_run_r && ev1_cnt_r == 6'h00 && pre_r == 15'h0000)
        else $error("first event did not restart both counters");

    a_bit2_zero: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_11]
        ctrl_wr && reg_wdata_i[`WTC_BIT_UNUSED] |=> ##1 !reg_rdata_o[`WTC_BIT_UNUSED])
        else $error("unused bit reads as one");

    c_first_event: cover property (@(posedge clk_i) disable iff (!resetn_i) wake_period_count_o);
    c_second_event: cover property (@(posedge clk_i) disable iff (!resetn_i) second_event_delay_o);
    c_recal: cover property (@(posedge clk_i) disable iff (!resetn_i)
        (osc_r == WTC_OSC_RUN) ##1 (osc_r == WTC_OSC_CAL));
endmodule

// file: verilog/wtc_defs.svh
// Purpose: Constants of the wake timer control block
// Assumes: Included by its bare name from every file that needs it
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef WTC_DEFS_SVH
`define WTC_DEFS_SVH

// Register map
`define WTC_ADDR_CTRL       8'h20

// Field positions in the control register
`define WTC_BIT_PD          7
`define WTC_EV1_HI          6
`define WTC_EV1_LO          4
`define WTC_BIT_CAL         3
`define WTC_BIT_UNUSED      2
`define WTC_RES_HI          1
`define WTC_RES_LO          0

// Reset values
`define WTC_RST_PD          1'b1
`define WTC_RST_EV1         3'h7
`define WTC_RST_CAL         1'b1
`define WTC_RST_RES         2'h0
`define WTC_RST_COUNT       16'h876B

// Crystal cycles per slow timer period
`define WTC_XOSC_DIV        750
// Slow periods spent in one calibration run
`define WTC_CAL_TICKS       4

`endif

// file: verilog/wtc_pkg.sv
// Purpose: Types of the wake timer control block
// Assumes: Constants live in wtc_defs.svh
// Notes:   Slow oscillator states
package wtc_pkg;

    typedef enum logic [1:0] {
        WTC_OSC_OFF,
        WTC_OSC_CAL,
        WTC_OSC_RUN
    } wtc_osc_t;

endpackage

// file: verilog/wtc_tick_if.sv
// Purpose: Carrier between the control logic and the slow clock divider
// Assumes: Single clock domain
// Notes:   tick is a one-cycle pulse per slow period
`timescale 1ns/1ns
interface wtc_tick_if;
    logic osc_run;
    logic tick;

    modport ctrl (output osc_run, input tick);
    modport div  (input osc_run, output tick);
endinterface

// file: verilog/wtc_divider.sv
// Purpose: Slow timer clock made from the crystal clock
// Assumes: clk_i is the crystal clock
// Notes:   Divider restarts from zero whenever the oscillator is off
`timescale 1ns/1ns
`include "wtc_defs.svh"
module wtc_divider
    import wtc_pkg::*;
#(
    parameter int DIV = `WTC_XOSC_DIV
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Tick carrier
    wtc_tick_if.div   tk
);
    localparam logic [9:0] DIV_LAST = 10'(DIV - 1);

    logic [9:0] div_r;
    logic       tick_r;
    logic [9:0] gap_r;
    logic       gap_ok_r;

    // Divide by DIV, one tick per wrap
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_r  <= 10'h000;
            tick_r <= 1'b0;
        end else if (!tk.osc_run) begin
            div_r  <= 10'h000;
            tick_r <= 1'b0;
        end else if (div_r == DIV_LAST) begin
            div_r  <= 10'h000;
            tick_r <= 1'b1; // [RULE_02]
        end else begin
            div_r  <= div_r + 10'h001;
            tick_r <= 1'b0;
        end
    end

    assign tk.tick = tick_r;

    // Helper: cycles since last tick, for the spacing check
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap_r    <= 10'h000;
            gap_ok_r <= 1'b0;
        end else if (!tk.osc_run) begin
            gap_r    <= 10'h000;
            gap_ok_r <= 1'b0;
        end else if (tick_r) begin
            gap_r    <= 10'h000;
            gap_ok_r <= 1'b1;
        end else begin
            gap_r    <= gap_r + 10'h001;
        end
    end

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RULE_02]
        tick_r && gap_ok_r |-> gap_r == DIV_LAST)
        else $error("slow tick spacing is not the divide ratio");

    c_tick_seen: cover property (@(posedge clk_i) disable iff (!resetn_i)
        tick_r && gap_ok_r);
endmodule

// file: verif/wake_timer_control_test.sv
// Purpose: Self-checking bench for the wake timer control block
// Assumes: Short divider and calibration counts keep the run brief
// Notes:   Inputs change at rising edges, outputs are sampled at falling edges
`timescale 1ns/1ns
`include "wtc_defs.svh"
module wake_timer_control_test;
    localparam int DIV  = 4;
    localparam int CALT = 2;
    // Design inputs
    logic        clk_i;
    logic        resetn_i;
    logic        reg_wr_i;
    logic [7:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic [15:0] wake_period_count_i;
    // Design outputs
    logic [7:0]  reg_rdata_o;
    logic        osc_on_o;
    logic        cal_busy_o;
    logic        cal_enable_o;
    logic        wake_period_count_o;
    logic        second_event_delay_o;
    // Bench state
    int          fail_count;
    int          total_checks;
    int          cyc;
    int          t0;
    int          t1;
    int          t2;
    int          ev1_tbl [8] = '{4, 6, 8, 12, 16, 24, 32, 48};

    wtc_top #(.DIV(DIV), .CAL_TICKS(CALT)) wtc_top_i (
        .clk_i               (clk_i),
        .resetn_i            (resetn_i),
        .reg_wr_i            (reg_wr_i),
        .reg_addr_i          (reg_addr_i),
        .reg_wdata_i         (reg_wdata_i),
        .reg_rdata_o         (reg_rdata_o),
        .wake_period_count_i (wake_period_count_i),
        .osc_on_o            (osc_on_o),
        .cal_busy_o          (cal_busy_o),
        .cal_enable_o        (cal_enable_o),
        .wake_period_count_o            (wake_period_count_o),
        .second_event_delay_o            (second_event_delay_o)
    );

    // Crystal clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Cycle stamp for interval measurement
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare a design value
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Compare a measured cycle count
    task automatic cmp_cnt(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // Present an address and compare the registered read data
    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        @(posedge clk_i);
        @(posedge clk_i);
        @(negedge clk_i);
        cmp_val({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask

    // Bounded wait for an event pulse, returns its cycle stamp
    task automatic wait_pulse(input bit sel, output int t);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(negedge clk_i);
            if ((sel ? second_event_delay_o : wake_period_count_o) === 1'b1) break;
        end
        t = cyc;
        if (i == 20000) begin
            fail_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, 0, 1);
            tally_and_finish();
        end
    endtask

    // Count event pulses over a quiet stretch
    task automatic quiet_check(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge clk_i);
            if (wake_period_count_o !== 1'b0 || second_event_delay_o !== 1'b0) hits++;
        end
        cmp_cnt(hits, 0);
    endtask

    // Main sequence
    initial begin
        resetn_i            = 1'b0;
        reg_wr_i            = 1'b0;
        reg_addr_i          = 8'h00;
        reg_wdata_i         = 8'h00;
        wake_period_count_i = 16'h0032;
        fail_count          = 0;
        total_checks        = 0;
        cyc                 = 0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;

        // Reset values, oscillator held off
        reg_check(`WTC_ADDR_CTRL, 8'hF8);
        cmp_val({15'h0000, osc_on_o}, 16'h0000);
        cmp_val({15'h0000, cal_enable_o}, 16'h0001);
        reg_check(8'h21, 8'h00);
        quiet_check(10 * DIV);
        $display("test reset_values done");

        // Field storage, unused bit, foreign address
        reg_write(8'h21, 8'h00);
        reg_check(`WTC_ADDR_CTRL, 8'hF8);
        reg_write(`WTC_ADDR_CTRL, 8'hF7);
        reg_check(`WTC_ADDR_CTRL, 8'hF3);
        cmp_val({15'h0000, cal_enable_o}, 16'h0000);
        reg_write(`WTC_ADDR_CTRL, 8'h8C);
        reg_check(`WTC_ADDR_CTRL, 8'h88);
        cmp_val({15'h0000, cal_enable_o}, 16'h0001);
        $display("test fields done");

        // Start, first event, second event, repetition
        reg_write(`WTC_ADDR_CTRL, 8'h00);
        @(negedge clk_i);
        t0 = cyc;
        @(negedge clk_i);
        cmp_val({14'h0000, osc_on_o, cal_busy_o}, 16'h0003);
        wait_pulse(1'b0, t1);
        cmp_cnt(t1 - t0, DIV * 50 + 1);
        cmp_val({15'h0000, cal_busy_o}, 16'h0000);
        wait_pulse(1'b1, t2);
        cmp_cnt(t2 - t1, DIV * 4);
        wait_pulse(1'b0, t0);
        cmp_cnt(t0 - t1, DIV * 50);
        // Calibration enabled: each first event recalibrates
        reg_write(`WTC_ADDR_CTRL, 8'h08);
        wait_pulse(1'b0, t1);
        cmp_val({15'h0000, cal_busy_o}, 16'h0001);
        $display("test start done");

        // Every second-event code
        for (int k = 0; k < 8; k++) begin
            reg_write(`WTC_ADDR_CTRL, {1'b0, k[2:0], 4'h0});
            wait_pulse(1'b0, t1);
            wait_pulse(1'b1, t2);
            cmp_cnt(t2 - t1, DIV * ev1_tbl[k]);
        end
        $display("test second_event done");

        // Resolution steps in continuous mode
        @(posedge clk_i);
        wake_period_count_i <= 16'h0001;
        for (int r = 0; r < 3; r++) begin
            reg_write(`WTC_ADDR_CTRL, {6'h00, r[1:0]});
            wait_pulse(1'b0, t0);
            wait_pulse(1'b0, t1);
            wait_pulse(1'b0, t2);
            cmp_cnt(t2 - t1, DIV << (5 * r));
        end
        $display("test resolution done");

        // Power down stops the timers
        reg_write(`WTC_ADDR_CTRL, 8'h80);
        repeat (2) @(negedge clk_i);
        cmp_val({15'h0000, osc_on_o}, 16'h0000);
        quiet_check(3 * DIV);
        $display("test power_down done");
        tally_and_finish();
    end
endmodule
